//--- bench/ead_mem_model.sv
// Memory-side model that ends each external access after a few wait states
`timescale 1ns/1ps
`default_nettype none
module ead_mem_model (
   input  wire logic       hclk,     // Bus clock
   input  wire logic       hresetn,  // Reset, active low
   input  wire logic       acc_busy, // Access in progress
   input  wire logic [1:0] delay,    // Wait states before the end pulse
   output logic            acc_end   // One-cycle end of access
);
   logic [1:0] cnt_ff; // Wait states served so far

   // Count wait states, then pulse the end for exactly one cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff  <= 2'h0;
         acc_end <= 1'b0;
      end else if (acc_end || !acc_busy) begin
         cnt_ff  <= 2'h0; // Idle or just ended: no pulse
         acc_end <= 1'b0;
      end else if (cnt_ff == delay) begin
         acc_end <= 1'b1; // Slow or prompt answer by delay
      end else begin
         cnt_ff <= cnt_ff + 2'h1;
      end
   end
endmodule : ead_mem_model
`default_nettype wire

//--- bench/external_area_decode_config_bench.sv
// Self-checking bench for the external area decoder and control register
`timescale 1ns/1ps
`default_nettype none
`include "ead_consts.svh"
module external_area_decode_config_bench import ead_pkg::*;;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        w_strap, e_strap, cap_w, cap_e, rd_ph_ff, busy_q_ff;
   logic        acc_req, acc_end, acc_busy, acc_reserved, acc_width8, acc_little;
   logic [1:0]  htrans, acc_mem_type, delay;
   logic [2:0]  hsize;
   logic [4:0]  chip_select_n;
   logic [5:0]  cfg [3:6];     // Area config values last written
   logic [31:0] haddr, hwdata, hrdata, acc_addr, lfsr;
   logic [31:0] reg_q [$];     // Expected read data
   logic [19:0] acc_q [$];     // Expected access outputs: mask, value
   int          bad_count, comparisons;
   assign hready = hreadyout; // Single slave drives bus ready

   ead_top u_ead_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .area0_width_strap(w_strap), .endian_strap(e_strap), .acc_req(acc_req),
      .acc_addr(acc_addr), .acc_end(acc_end), .acc_busy(acc_busy),
      .chip_select_n(chip_select_n), .acc_reserved(acc_reserved),
      .acc_width8(acc_width8), .acc_mem_type(acc_mem_type), .acc_little(acc_little));
   ead_mem_model u_ead_mem_model (.hclk(hclk), .hresetn(hresetn), .acc_busy(acc_busy),
      .delay(delay), .acc_end(acc_end));

   // Free-running bus clock
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   // Random source for addresses, widths and delays
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : nxt

   // Compare and count
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Counts, verdict and end of run
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : final_report

   // Expected select, reserved flag, width, type and endian of one access
   function automatic logic [19:0] exp_acc(input logic [31:0] a, input logic map2);
      logic [2:0] ar;
      logic [5:0] c;
      logic [1:0] t;
      ar = a[28:26];
      if (ar == 3'h0) return {10'h3FF, 5'h1E, 1'b0, cap_w, 2'h0, cap_e};
      // Reserved: no select, reserved flag and endian still shown
      if (ar < 3'h3 || ar == 3'h7 || (ar > 3'h4 && !map2 && !a[25]))
         return {10'h3F1, 5'h1F, 1'b1, 3'h0, cap_e};
      c = cfg[ar];
      t = c[5:4];
      if (t == MT_SDRAM && ar != 3'h3) t = MT_NORMAL; // SDRAM only in area 3
      if (t == MT_PCMCIA && !(map2 && ar > 3'h4)) t = MT_NORMAL;
      return {10'h3FF, ~(5'h01 << (ar - 3'h2)), 1'b0, c[0], t, cap_e};
   endfunction : exp_acc

   // Wait for the slave to be ready at a rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
   endtask : wait_rdy

   // One single-word transfer; for a read, d is the expected data
   task automatic bus(input logic [7:0] off, input logic wr, input logic [31:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {24'h0, off};
      wait_rdy();
      htrans <= 2'h0;
      hsel   <= 1'b0;
      hwdata <= wr ? d : ~d;
      if (!wr) reg_q.push_back(d);
      wait_rdy();
   endtask : bus

   // One external access, requested for one cycle, then run to its end
   task automatic access(input logic [31:0] a, input logic map2);
      int n;
      acc_q.push_back(exp_acc(a, map2));
      @(posedge hclk);
      acc_req  <= 1'b1;
      acc_addr <= a;
      delay    <= lfsr[1:0];
      lfsr = nxt(lfsr);
      @(posedge hclk);
      acc_req  <= 1'b0;
      acc_addr <= ~a;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (acc_busy !== 1'b0 && n < 20);
   endtask : access

   // Reset with given straps, then flip the pins once they are captured
   task automatic do_reset(input logic w, input logic e);
      @(posedge hclk);
      hresetn <= 1'b0;
      w_strap <= w;
      e_strap <= e;
      cap_w = w;
      cap_e = e;
      for (int j = 3; j < 7; j++) cfg[j] = 6'h00;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      w_strap <= ~w;
      e_strap <= ~e;
   endtask : do_reset

   // Monitor: take the oldest note whenever a result appears
   always @(posedge hclk) begin
      logic [19:0] n;
      if (rd_ph_ff) check("hrdata", hrdata, reg_q.pop_front());
      if (hready) rd_ph_ff <= hsel & htrans[1] & !hwrite;
      if (acc_busy === 1'b1 && busy_q_ff === 1'b0) begin
         n = acc_q.pop_front();
         check("access", {22'h0, n[19:10] & {chip_select_n, acc_reserved, acc_width8,
            acc_mem_type, acc_little}}, {22'h0, n[19:10] & n[9:0]});
      end
      busy_q_ff <= acc_busy;
   end

   // Watchdog against a hung handshake
   initial begin
      #400000;
      bad_count++;
      final_report();
   end

   // Main sequence
   initial begin
      int r, m, k, i;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      w_strap = 1'b1;
      e_strap = 1'b1;
      acc_req = 1'b0;
      acc_addr = 32'h0;
      delay = 2'h0;
      rd_ph_ff = 1'b0;
      busy_q_ff = 1'b0;
      bad_count = 0;
      comparisons = 0;
      lfsr = 32'h1CA1;
      do_reset(1'b1, 1'b1);
      bus(`EAD_OFF_STAT, 1'b0, 32'h0000_0003);
      bus(`EAD_OFF_CBC, 1'b0, 32'h0000_001C);
      bus(`EAD_OFF_CBC, 1'b1, 32'hFFFF_FFFF);
      bus(`EAD_OFF_CBC, 1'b0, 32'h0000_101C);
      bus(8'h40, 1'b0, 32'h0000_0000);
      for (r = 0; r < 4; r++) begin
         for (i = 3; i < 7; i++) begin
            cfg[i] = {r[1:0], 3'h0, lfsr[i]};
            bus(8'(4 * (i - 2)), 1'b1, {26'h0, cfg[i]});
            bus(8'(4 * (i - 2)), 1'b0, {26'h0, cfg[i]});
         end
         lfsr = nxt(lfsr);
         for (m = 0; m < 2; m++) begin
            bus(`EAD_OFF_CBC, 1'b1, 32'h0000_0014 | (32'(m) << 12));
            for (k = 0; k < 16; k++) begin
               access({lfsr[31:29], k[3:0], lfsr[24:0]}, m[0]);
               lfsr = nxt(lfsr);
            end
         end
      end
      do_reset(1'b0, 1'b0);
      bus(`EAD_OFF_CBC, 1'b0, 32'h0000_0014);
      access(32'hE012_3456, 1'b0);
      access(32'h1A00_0000, 1'b0);
      bus(`EAD_OFF_STAT, 1'b0, 32'h0000_0060);
      final_report();
   end
endmodule : external_area_decode_config_bench
`default_nettype wire

//--- rtl/ead_area_dec.sv
// Combinational area decoder for the external physical space
`timescale 1ns/1ps
`default_nettype none
module ead_area_dec
   import ead_pkg::*;
(
   input  wire logic [2:0] area,      // Address bits 28:26
   input  wire logic       half_hi,   // Address bit 25
   input  wire logic       map2,      // Map 2 selected
   output logic [4:0]      sel,       // One-hot: areas 0,3,4,5,6
   output logic            reserved   // Address hits a reserved area
);
   // Area numbers owning each chip select
   localparam logic [2:0] CS_AREA [5] = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6};

   // One comparator per chip select; lower halves of 5 and 6 only in map 2
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_cs
         if (g >= 3) begin : g_split
            assign sel[g] = (area == CS_AREA[g]) && (map2 || half_hi);
         end else begin : g_full
            assign sel[g] = (area == CS_AREA[g]);
         end
      end
   endgenerate

   // Areas 1, 2, 7 and the split lower halves have no select
   assign reserved = ~|sel;
endmodule : ead_area_dec
`default_nettype wire

//--- rtl/ead_consts.svh
// Offsets, field positions, reset values and counts of the area decoder
`ifndef EAD_CONSTS_SVH
`define EAD_CONSTS_SVH
// Register byte offsets (low address byte)
`define EAD_OFF_CBC      8'h00
`define EAD_OFF_CFG3     8'h04
`define EAD_OFF_CFG4     8'h08
`define EAD_OFF_CFG5     8'h0C
`define EAD_OFF_CFG6     8'h10
`define EAD_OFF_STAT     8'h14
// Common bus control fields
`define EAD_CBC_MAP      12
`define EAD_CBC_ENDIAN   3
`define EAD_CBC_ONE_HI   4
`define EAD_CBC_ONE_LO   2
`define EAD_MAP_RST      1'h0
// Area config fields: bit 0 width (1 = 8 bit), bits 5:4 memory type
`define EAD_CFG_W8       0
`define EAD_CFG_TYPE_LO  4
`define EAD_CFG_RST      6'h00
// Status fields
`define EAD_ST_W8        0
`define EAD_ST_ENDIAN    1
`define EAD_ST_AREA_LO   4
`define EAD_ST_BUSY      8
// Area codes from address bits 28:25
`define EAD_AREA_MSB     28
`define EAD_AREA_LSB     25
`define EAD_NUM_CS       5
`define EAD_SPACE_MBYTE  256
`endif

//--- rtl/ead_pkg.sv
// Types shared by the area decoder files
package ead_pkg;
   // Memory kinds an area can hold
   typedef enum logic [1:0] {
      MT_NORMAL = 2'h0,
      MT_BSRAM  = 2'h1,
      MT_SDRAM  = 2'h2,
      MT_PCMCIA = 2'h3
   } ead_mem_type;
   // External access sequencer
   typedef enum logic {ACC_IDLE, ACC_BUSY} ead_acc_state_type;
endpackage : ead_pkg

//--- rtl/ead_top.sv
// External area decoder, strap capture and common bus control register
`timescale 1ns/1ps
`default_nettype none
`include "ead_consts.svh"
module ead_top
   import ead_pkg::*;
(
   input  wire logic        hclk,              // Bus clock
   input  wire logic        hresetn,           // Power-on reset, active low
   input  wire logic        hsel,              // Slave select
   input  wire logic [31:0] haddr,             // Byte address
   input  wire logic [1:0]  htrans,            // Transfer type
   input  wire logic        hwrite,            // Write when high
   input  wire logic [2:0]  hsize,             // Transfer size
   input  wire logic [31:0] hwdata,            // Write data
   input  wire logic        hready,            // Bus ready
   output logic             hreadyout,         // Slave ready
   output logic [31:0]      hrdata,            // Read data
   output logic             hresp,             // Always OKAY
   input  wire logic        area0_width_strap, // 1 = 8-bit area 0
   input  wire logic        endian_strap,      // 1 = little endian
   input  wire logic        acc_req,           // External access request
   input  wire logic [31:0] acc_addr,          // Access physical address
   input  wire logic        acc_end,           // Access finished
   output logic             acc_busy,          // Access in progress
   output logic [4:0]       chip_select_n,     // Bit 0 area0_chip_select
   output logic             acc_reserved,      // Access hit reserved area
   output logic             acc_width8,        // Access bus is 8 bits
   output logic [1:0]       acc_mem_type,      // Memory kind of access
   output logic             acc_little         // Little-endian alignment
);
   // Register state
   logic              map_ff;         // Map select
   logic              a0_w8_ff;       // Area 0 is 8 bits
   logic              endian_ff;      // Little endian
   logic              strap_done_ff;  // Straps captured
   logic [5:0]        cfg_ff [4];     // Areas 3, 4, 5(B), 6(B)
   // Bus data phase
   logic              dp_wr_ff;       // Write data phase pending
   logic              dp_rd_ff;       // Read data phase pending
   logic [7:0]        dp_addr_ff;     // Latched offset
   logic [31:0]       hrdata_ff;      // Read data
   // Access outputs
   ead_acc_state_type acc_st_ff;      // Sequencer
   logic [4:0]        cs_n_ff;        // Chip selects
   logic              acc_res_ff;     // Reserved hit
   logic              acc_w8_ff;      // Width 8
   logic [1:0]        acc_type_ff;    // Memory type
   logic [2:0]        last_area_ff;   // Last decoded area
   // Decode wires
   logic [4:0]        dec_sel;        // One-hot decode
   logic              dec_res;        // Reserved
   logic              take;           // Access accepted
   logic              ahb_go;         // Valid address phase
   logic              nxt_w8;         // Width of new access
   logic [1:0]        nxt_type;       // Type of new access
   logic [31:0]       rd_mux;         // Read value

   assign take   = acc_req && (acc_st_ff == ACC_IDLE);
   assign ahb_go = hsel && htrans[1] && hready;

   // Address decode with the live map
   ead_area_dec u_dec (
      .area     (acc_addr[`EAD_AREA_MSB:`EAD_AREA_LSB+1]),
      .half_hi  (acc_addr[`EAD_AREA_LSB]),
      .map2     (map_ff),
      .sel      (dec_sel),
      .reserved (dec_res)
   );

   // Width and memory kind of the new access
   always_comb begin
      nxt_w8   = a0_w8_ff;
      nxt_type = MT_NORMAL;
      for (int i = 0; i < 4; i++) begin
         if (dec_sel[i+1]) begin
            nxt_w8   = cfg_ff[i][`EAD_CFG_W8];
            nxt_type = cfg_ff[i][`EAD_CFG_TYPE_LO+:2];
         end
      end
      // Illegal kinds fall back to normal memory
      if ((nxt_type == MT_SDRAM) && !dec_sel[1]) begin
         nxt_type = MT_NORMAL;
      end
      if ((nxt_type == MT_PCMCIA) && !(map_ff && (dec_sel[3] || dec_sel[4]))) begin
         nxt_type = MT_NORMAL;
      end
   end

   // Strap capture on the first edge after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_done_ff <= 1'b0;
         a0_w8_ff      <= 1'b0;
         endian_ff     <= 1'b0;
      end else if (!strap_done_ff) begin
         strap_done_ff <= 1'b1;
         a0_w8_ff      <= area0_width_strap;
         endian_ff     <= endian_strap;
      end
   end

   // Bus address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_wr_ff   <= 1'b0;
         dp_rd_ff   <= 1'b0;
         dp_addr_ff <= 8'h00;
      end else if (hready) begin
         dp_wr_ff   <= ahb_go && hwrite;
         dp_rd_ff   <= ahb_go && !hwrite;
         dp_addr_ff <= haddr[7:0];
      end
   end

   // Register writes at the end of the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         map_ff <= `EAD_MAP_RST;
         for (int i = 0; i < 4; i++) begin
            cfg_ff[i] <= `EAD_CFG_RST;
         end
      end else if (dp_wr_ff) begin
         unique case (dp_addr_ff)
            `EAD_OFF_CBC:  map_ff    <= hwdata[`EAD_CBC_MAP];
            `EAD_OFF_CFG3: cfg_ff[0] <= hwdata[5:0];
            `EAD_OFF_CFG4: cfg_ff[1] <= hwdata[5:0];
            `EAD_OFF_CFG5: cfg_ff[2] <= hwdata[5:0];
            `EAD_OFF_CFG6: cfg_ff[3] <= hwdata[5:0];
            default:       ;                                  // Unmapped ignored
         endcase
      end
   end

   // Read value by offset
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr[7:0])
         `EAD_OFF_CBC: begin
            rd_mux[`EAD_CBC_MAP]    = map_ff;
            rd_mux[`EAD_CBC_ONE_HI] = 1'b1;
            rd_mux[`EAD_CBC_ENDIAN] = endian_ff;
            rd_mux[`EAD_CBC_ONE_LO] = 1'b1;
         end
         `EAD_OFF_CFG3: rd_mux[5:0] = cfg_ff[0];
         `EAD_OFF_CFG4: rd_mux[5:0] = cfg_ff[1];
         `EAD_OFF_CFG5: rd_mux[5:0] = cfg_ff[2];
         `EAD_OFF_CFG6: rd_mux[5:0] = cfg_ff[3];
         `EAD_OFF_STAT: begin
            rd_mux[`EAD_ST_W8]             = a0_w8_ff;
            rd_mux[`EAD_ST_ENDIAN]         = endian_ff;
            rd_mux[`EAD_ST_AREA_LO+:3]     = last_area_ff;
            rd_mux[`EAD_ST_BUSY]           = (acc_st_ff == ACC_BUSY);
         end
         default: ;                                           // Unmapped reads 0
      endcase
   end

   // Read data loaded at the address phase edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_ff <= 32'h0000_0000;
      end else if (hready) begin
         hrdata_ff <= (ahb_go && !hwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // Access sequencer: decode frozen for the whole access
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_st_ff    <= ACC_IDLE;
         cs_n_ff      <= 5'h1F;
         acc_res_ff   <= 1'b0;
         acc_w8_ff    <= 1'b0;
         acc_type_ff  <= MT_NORMAL;
         last_area_ff <= 3'h0;
      end else begin
         unique case (acc_st_ff)
            ACC_IDLE: begin
               if (take) begin
                  acc_st_ff    <= ACC_BUSY;
                  cs_n_ff      <= ~dec_sel;
                  acc_res_ff   <= dec_res;
                  acc_w8_ff    <= nxt_w8;
                  acc_type_ff  <= nxt_type;
                  last_area_ff <= acc_addr[`EAD_AREA_MSB:`EAD_AREA_LSB+1];
               end
            end
            ACC_BUSY: begin
               if (acc_end) begin
                  acc_st_ff  <= ACC_IDLE;
                  cs_n_ff    <= 5'h1F;
                  acc_res_ff <= 1'b0;
               end
            end
         endcase
      end
   end

   // Outputs straight from flops, ready and response tied to constants
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign hrdata        = hrdata_ff;
   assign acc_busy      = (acc_st_ff == ACC_BUSY);
   assign chip_select_n = cs_n_ff;
   assign acc_reserved  = acc_res_ff;
   assign acc_width8    = acc_w8_ff;
   assign acc_mem_type  = acc_type_ff;
   assign acc_little    = endian_ff;

   // Checks
   sequence s_take;
      acc_req && (acc_st_ff == ACC_IDLE);
   endsequence
   sequence s_cbc_read;
      ahb_go && !hwrite && (haddr[7:0] == `EAD_OFF_CBC);
   endsequence

   property p_straps_hold;
      @(posedge hclk) disable iff (!hresetn)
      strap_done_ff && $past(strap_done_ff) |-> $stable(endian_ff) && $stable(a0_w8_ff);
   endproperty
   a_straps_hold: assert property (p_straps_hold) else $error("strap value changed");

   property p_strap_capture;
      @(posedge hclk) disable iff (!hresetn)
      $rose(strap_done_ff) |-> (a0_w8_ff == $past(area0_width_strap))
                               && (endian_ff == $past(endian_strap));
   endproperty
   a_strap_capture: assert property (p_strap_capture) else $error("strap not captured");

   property p_cbc_read;
      @(posedge hclk) disable iff (!hresetn)
      s_cbc_read |=> (hrdata[31:13] == 19'h0) && (hrdata[11:5] == 7'h0) && hrdata[4]
                     && hrdata[2] && (hrdata[3] == endian_ff) && (hrdata[12] == $past(map_ff));
   endproperty
   a_cbc_read: assert property (p_cbc_read) else $error("bad control read");

   property p_map_write;
      @(posedge hclk) disable iff (!hresetn)
      dp_wr_ff && (dp_addr_ff == `EAD_OFF_CBC) |=> map_ff == $past(hwdata[`EAD_CBC_MAP]);
   endproperty
   a_map_write: assert property (p_map_write) else $error("map bit not written");

   property p_take_decode;
      @(posedge hclk) disable iff (!hresetn)
      s_take |=> acc_busy && (chip_select_n == ~$past(dec_sel))
                 && (acc_reserved == $past(dec_res));
   endproperty
   a_take_decode: assert property (p_take_decode) else $error("decode not applied");

   property p_cs_onehot;
      @(posedge hclk) disable iff (!hresetn)
      $onehot0(~chip_select_n) && (acc_busy || (chip_select_n == 5'h1F));
   endproperty
   a_cs_onehot: assert property (p_cs_onehot) else $error("chip select not one-hot");

   property p_frozen;
      @(posedge hclk) disable iff (!hresetn)
      acc_busy && !acc_end |=> $stable(chip_select_n) && $stable(acc_mem_type);
   endproperty
   a_frozen: assert property (p_frozen) else $error("access changed mid-flight");

   property p_pcmcia;
      @(posedge hclk) disable iff (!hresetn)
      s_take ##1 (acc_mem_type == MT_PCMCIA) |-> $past(map_ff) && (chip_select_n[4:3] != 2'h3);
   endproperty
   a_pcmcia: assert property (p_pcmcia) else $error("pcmcia outside map 2 area 5/6");

   property p_sdram;
      @(posedge hclk) disable iff (!hresetn)
      acc_busy && (acc_mem_type == MT_SDRAM) |-> !chip_select_n[1];
   endproperty
   a_sdram: assert property (p_sdram) else $error("sdram outside area 3");

   property p_map1_split;
      @(posedge hclk) disable iff (!hresetn)
      (s_take and (!map_ff && (acc_addr[28:25] == 4'hA)))
         |=> acc_reserved && (chip_select_n == 5'h1F);
   endproperty
   a_map1_split: assert property (p_map1_split) else $error("area 5A not reserved");
endmodule : ead_top
`default_nettype wire
